// *** core/ftc_phy_control.sv ***
// Control logic of the fault-tolerant CAN transceiver
module ftc_phy_control (
    input  wire logic                  clk,            // 100 MHz system clock
    input  wire logic                  reset,          // Synchronous reset, active high
    input  wire logic                  txData,         // Transmit data pin, low is dominant
    input  wire logic                  standby_ctrl_in,// Standby control pin
    input  wire logic                  enableCtrl,     // Enable control pin
    input  wire logic                  wakeLocal_n,    // Local wake pin, active low
    input  wire logic                  battery_supply, // Battery power-on event pin
    input  wire ftc_pkg::ftc_bus_sense_t busSense,     // Filtered comparator results
    output logic                       rxData,         // Receive data, low is dominant
    output logic                       errInd_n,       // Error/wake/power-on indication
    output logic                       regulator_inhibit_out, // Regulator enable
    output ftc_pkg::ftc_drive_t        busDrive,       // Driver and termination controls
    output ftc_pkg::ftc_mode_t         modeState       // Current transceiver mode
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 12;
    logic [SYNC_W-1:0] syncA_reg;
    logic [SYNC_W-1:0] syncB_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            // Idle pin levels, so no false mode or wake edge
            syncA_reg <= ftc_pkg::SYNC_RESET;
            syncB_reg <= ftc_pkg::SYNC_RESET;
        end
        else
        begin
            syncA_reg <= {txData, standby_ctrl_in, enableCtrl, wakeLocal_n, battery_supply,
                          busSense, 2'b11};
            syncB_reg <= syncA_reg;
        end
    end

    logic                     txS;
    logic                     stbS;
    logic                     enS;
    logic                     wakeS_n;
    logic                     batS;
    ftc_pkg::ftc_bus_sense_t  senseS;
    assign txS     = syncB_reg[11];
    assign stbS    = syncB_reg[10];
    assign enS     = syncB_reg[9];
    assign wakeS_n = syncB_reg[8];
    assign batS    = syncB_reg[7];
    assign senseS  = syncB_reg[6:2];

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    function automatic ftc_pkg::ftc_mode_t decodeMode(input logic stb, input logic en,
                                                     input ftc_pkg::ftc_mode_t cur);
        ftc_pkg::ftc_mode_t m;
        m = cur;
        case ({stb, en})
            2'b11:   m = ftc_pkg::MODE_NORMAL;
            2'b10:   m = ftc_pkg::MODE_PWRON_SBY;
            2'b01:   m = ftc_pkg::MODE_GOTOSLEEP;
            2'b00:   m = (cur == ftc_pkg::MODE_GOTOSLEEP || cur == ftc_pkg::MODE_SLEEP) ?
                         ftc_pkg::MODE_SLEEP : ftc_pkg::MODE_STANDBY;
            default: m = ftc_pkg::MODE_STANDBY;
        endcase
        return m;
    endfunction : decodeMode

    ftc_pkg::ftc_mode_t mode_reg;
    ftc_pkg::ftc_mode_t mode_next;
    logic               normal;
    assign normal = (mode_reg == ftc_pkg::MODE_NORMAL);

    // ------------------------------------------------------------
    // Transmit dominant time-out
    // ------------------------------------------------------------
    logic txTimedOut;
    // Any high level restarts the count
    ftc_timeout_counter #(
        .LIMIT (ftc_pkg::TXD_TIMEOUT_CYC)
    ) u_txTimeout (
        .clk     (clk),
        .reset   (reset),
        .clear   (txS),
        .run     (!txS),
        .expired (txTimedOut)
    );

    // ------------------------------------------------------------
    // Failure detector timers
    // ------------------------------------------------------------
    logic overT1;
    logic overT2;
    logic recessiveLong;
    logic overRun;
    // Both time-outs count from the onset of over-voltage
    assign overRun = normal && senseS.highOverVolt;

    ftc_timeout_counter #(
        .LIMIT (ftc_pkg::FAIL_T1_CYC)
    ) u_failT1 (
        .clk     (clk),
        .reset   (reset),
        .clear   (1'b0),
        .run     (overRun),
        .expired (overT1)
    );

    ftc_timeout_counter #(
        .LIMIT (ftc_pkg::FAIL_T2_CYC)
    ) u_failT2 (
        .clk     (clk),
        .reset   (reset),
        .clear   (1'b0),
        .run     (overRun),
        .expired (overT2)
    );

    ftc_timeout_counter #(
        .LIMIT (ftc_pkg::RECOVER_CYC)
    ) u_recover (
        .clk     (clk),
        .reset   (reset),
        .clear   (1'b0),
        .run     (!senseS.highOverVolt && !senseS.highDominant),
        .expired (recessiveLong)
    );

    // ------------------------------------------------------------
    // State: mode, failure path, wake and flags
    // ------------------------------------------------------------
    ftc_pkg::ftc_fail_t fail_reg;
    ftc_pkg::ftc_fail_t fail_next;
    logic               wakePrev_reg;
    logic               wakePrev_next;
    logic               wakeFlag_reg;
    logic               wakeFlag_next;
    logic               pwrOn_reg;
    logic               pwrOn_next;
    logic               inhibit_reg;
    logic               inhibit_next;
    logic               rx_reg;
    logic               rx_next;
    logic               err_reg;
    logic               err_next;
    ftc_pkg::ftc_drive_t drive_reg;
    ftc_pkg::ftc_drive_t drive_next;
    logic               wakeEdge;

    // Either edge of the synced wake pin
    assign wakeEdge = (wakeS_n != wakePrev_reg);

    always_comb
    begin
        mode_next     = decodeMode(stbS, enS, mode_reg);
        wakePrev_next = wakeS_n;
        wakeFlag_next = wakeFlag_reg;
        pwrOn_next    = pwrOn_reg | batS;
        inhibit_next  = 1'b1;

        // Clear on entry to normal, a wake edge in that cycle still sets
        if (mode_next == ftc_pkg::MODE_NORMAL)
            wakeFlag_next = 1'b0;
        if (!normal && wakeEdge)
            wakeFlag_next = 1'b1;
        // Regulator off only in sleep with no wake pending
        if (mode_reg == ftc_pkg::MODE_SLEEP && !wakeFlag_next)
            inhibit_next = 1'b0;
        if (normal && !batS)
            pwrOn_next = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mode_reg     <= ftc_pkg::MODE_STANDBY;
            wakePrev_reg <= 1'b1;
            wakeFlag_reg <= 1'b0;
            pwrOn_reg    <= 1'b1;
            inhibit_reg  <= 1'b1;
        end
        else
        begin
            mode_reg     <= mode_next;
            wakePrev_reg <= wakePrev_next;
            wakeFlag_reg <= wakeFlag_next;
            pwrOn_reg    <= pwrOn_next;
            inhibit_reg  <= inhibit_next;
        end
    end

    // ------------------------------------------------------------
    // Failure path selection
    // ------------------------------------------------------------
    always_comb
    begin
        fail_next = fail_reg;

        if (normal)
        begin
            case (fail_reg)
                ftc_pkg::FS_DIFF:
                    if (overT1)
                        fail_next = ftc_pkg::FS_HIGH_ONLY;
                ftc_pkg::FS_HIGH_ONLY:
                    if (overT2)
                        fail_next = ftc_pkg::FS_LOW_ONLY;
                    else if (recessiveLong)
                        fail_next = ftc_pkg::FS_DIFF;
                ftc_pkg::FS_LOW_ONLY:
                    if (recessiveLong)
                        fail_next = ftc_pkg::FS_DIFF;
                default:
                    fail_next = ftc_pkg::FS_DIFF;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            fail_reg <= ftc_pkg::FS_DIFF;
        else
            fail_reg <= fail_next;
    end

    // ------------------------------------------------------------
    // Drivers, receive data and indication
    // ------------------------------------------------------------
    always_comb
    begin
        // Drivers and terminations
        drive_next.highDriverOn         = (fail_next != ftc_pkg::FS_LOW_ONLY);
        drive_next.lowDriverOn          = 1'b1;
        drive_next.highTermWeakPulldown = (fail_next == ftc_pkg::FS_LOW_ONLY);
        drive_next.lowTermWeakPullup    = 1'b0;
        drive_next.dominant             = normal && !txS && !txTimedOut;

        // Receive path
        case (fail_next)
            ftc_pkg::FS_DIFF:      rx_next = !senseS.diffDominant;
            ftc_pkg::FS_HIGH_ONLY: rx_next = !senseS.highDominant;
            ftc_pkg::FS_LOW_ONLY:  rx_next = !senseS.lowDominant;
            default:               rx_next = 1'b1;
        endcase
        if (!normal)
            rx_next = !wakeFlag_next;

        // Indication output
        case (mode_reg)
            ftc_pkg::MODE_NORMAL:
                err_next = !(senseS.wireFault || fail_next != ftc_pkg::FS_DIFF);
            ftc_pkg::MODE_PWRON_SBY:
                err_next = !pwrOn_next;
            default:
                err_next = !wakeFlag_next;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rx_reg       <= 1'b1;
            err_reg      <= 1'b1;
            drive_reg    <= ftc_pkg::DRIVE_RESET;
        end
        else
        begin
            rx_reg       <= rx_next;
            err_reg      <= err_next;
            drive_reg    <= drive_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rxData                = rx_reg;
    assign errInd_n              = err_reg;
    assign regulator_inhibit_out = inhibit_reg;
    assign busDrive              = drive_reg;
    assign modeState             = mode_reg;

endmodule : ftc_phy_control

// *** core/ftc_pkg.sv ***
// Package: constants and carrier types of the fault-tolerant CAN transceiver control
package ftc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 10;
    localparam int TXD_TIMEOUT_CYC    = 10000;
    localparam int FAIL_T1_CYC        = 4000;
    localparam int FAIL_T2_CYC        = 8000;
    localparam int RECOVER_CYC        = 4000;
    localparam int WAKE_FILTER_CYC    = 3;
    localparam int CNT_W              = 24;

    // ------------------------------------------------------------
    // Modes from standby and enable inputs
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SLEEP     = 3'b000,
        MODE_GOTOSLEEP = 3'b001,
        MODE_PWRON_SBY = 3'b010,
        MODE_NORMAL    = 3'b011,
        MODE_STANDBY   = 3'b100
    } ftc_mode_t;

    // Failure path states
    typedef enum logic [1:0] {
        FS_DIFF      = 2'b00,
        FS_HIGH_ONLY = 2'b01,
        FS_LOW_ONLY  = 2'b10
    } ftc_fail_t;

    // Bus comparator results
    typedef struct packed {
        logic diffDominant;
        logic highOverVolt;
        logic highDominant;
        logic lowDominant;
        logic wireFault;
    } ftc_bus_sense_t;

    // Driver and termination controls
    typedef struct packed {
        logic highDriverOn;
        logic lowDriverOn;
        logic highTermWeakPulldown;
        logic lowTermWeakPullup;
        logic dominant;
    } ftc_drive_t;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Synchroniser word: transmit high, controls low, wake high, bus idle
    localparam logic [11:0] SYNC_RESET  = 12'h903;
    localparam ftc_drive_t  DRIVE_RESET = 5'h18;

endpackage : ftc_pkg

// *** core/ftc_timeout_counter.sv ***
// Saturating cycle counter that flags when a held condition exceeds a limit
module ftc_timeout_counter #(
    parameter int LIMIT = 16
) (
    input  wire logic clk,      // System clock
    input  wire logic reset,    // Synchronous reset, active high
    input  wire logic clear,    // Restart counting from zero
    input  wire logic run,      // Count while high
    output logic      expired   // Held condition exceeded LIMIT
);
    logic [ftc_pkg::CNT_W-1:0] count_reg;
    logic [ftc_pkg::CNT_W-1:0] count_next;
    logic                      expired_reg;
    logic                      expired_next;

    always_comb
    begin
        count_next   = count_reg;
        expired_next = expired_reg;
        if (clear || !run)
        begin
            count_next   = '0;
            expired_next = 1'b0;
        end
        else if (count_reg >= ftc_pkg::CNT_W'(LIMIT))
        begin
            expired_next = 1'b1;
        end
        else
        begin
            count_next = count_reg + ftc_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count_reg   <= '0;
            expired_reg <= 1'b0;
        end
        else
        begin
            count_reg   <= count_next;
            expired_reg <= expired_next;
        end
    end

    assign expired = expired_reg;
endmodule : ftc_timeout_counter

// *** tb/ftc_ctrl_model.sv ***
// Protocol controller model driving the transmit pin
module ftc_ctrl_model #(
    parameter int BIT_CYC = 20
) (
    input  wire logic       clk,    // System clock
    input  wire logic       start,  // Begin a frame
    input  wire logic [7:0] frame,  // Frame bits, MSB first
    input  wire logic       stuck,  // Faulty controller holds pin low
    output logic            txData  // Transmit pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] shift_reg = 8'hff;
    int         left      = 0;
    int         cyc       = 0;
    always @(posedge clk)
    begin
        if (start && left == 0)
        begin
            shift_reg <= frame;
            left      <= 8;
            cyc       <= BIT_CYC - 1;
        end
        else if (left != 0 && cyc == 0)
        begin
            shift_reg <= {shift_reg[6:0], 1'b1};
            left      <= left - 1;
            cyc       <= BIT_CYC - 1;
        end
        else if (left != 0)
            cyc <= cyc - 1;
    end
    // Idle high between frames
    assign txData = stuck ? 1'b0 : ((left != 0) ? shift_reg[7] : 1'b1);
endmodule : ftc_ctrl_model

// *** tb/ftc_phy_control_assertions.sv ***
// Checker: timing properties on the transceiver control ports
module ftc_phy_control_chk (
    input wire logic                    clk,                   // System clock
    input wire logic                    reset,                 // Sync reset
    input wire logic                    txData,                // Transmit pin
    input wire logic                    standby_ctrl_in,       // Standby pin
    input wire logic                    enableCtrl,            // Enable pin
    input wire logic                    wakeLocal_n,           // Local wake pin
    input wire logic                    battery_supply,        // Power-on pin
    input wire ftc_pkg::ftc_bus_sense_t busSense,              // Comparators
    input wire logic                    rxData,                // Receive data
    input wire logic                    errInd_n,              // Indication
    input wire logic                    regulator_inhibit_out, // Regulator enable
    input wire ftc_pkg::ftc_drive_t     busDrive,              // Drivers
    input wire ftc_pkg::ftc_mode_t      modeState              // Mode
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TXD_LIM = ftc_pkg::TXD_TIMEOUT_CYC + 4;
    localparam int T1_LIM  = ftc_pkg::FAIL_T1_CYC + 8;
    localparam int T2_LIM  = ftc_pkg::FAIL_T2_CYC + 8;
    int lowCnt_reg;
    int ovCnt_reg;
    // Run lengths of low transmit and of over-voltage in normal mode
    always_ff @(posedge clk)
    begin
        lowCnt_reg <= (reset || txData) ? 0 : lowCnt_reg + 1;
        ovCnt_reg  <= (reset || !busSense.highOverVolt || modeState != ftc_pkg::MODE_NORMAL)
                      ? 0 : ovCnt_reg + 1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_dom_cause;
        busDrive.dominant |-> !$past(txData, 2) || !$past(txData, 3) || !$past(txData, 4);
    endproperty
    property p_dom_tout;
        lowCnt_reg > TXD_LIM |-> !busDrive.dominant;
    endproperty
    property p_mode_norm;
        (standby_ctrl_in && enableCtrl) [*5] |-> modeState == ftc_pkg::MODE_NORMAL;
    endproperty
    property p_mode_pwr;
        (standby_ctrl_in && !enableCtrl) [*5] |-> modeState == ftc_pkg::MODE_PWRON_SBY;
    endproperty
    property p_inh;
        !regulator_inhibit_out |->
            modeState == ftc_pkg::MODE_SLEEP || $past(modeState) == ftc_pkg::MODE_SLEEP;
    endproperty
    property p_wake;
        modeState == ftc_pkg::MODE_SLEEP && $changed(wakeLocal_n) |->
            ##[1:8] (!errInd_n && regulator_inhibit_out);
    endproperty
    property p_wire;
        (modeState == ftc_pkg::MODE_NORMAL && busSense.wireFault) [*5] |-> !errInd_n;
    endproperty
    property p_off_bias;
        !busDrive.highDriverOn |-> busDrive.highTermWeakPulldown && busDrive.lowDriverOn;
    endproperty
    property p_ov1;
        ovCnt_reg == T1_LIM |-> !errInd_n;
    endproperty
    property p_ov2;
        ovCnt_reg > T2_LIM |-> !busDrive.highDriverOn;
    endproperty
    a_dom_cause: assert property (p_dom_cause) else $error("dominant without low tx");
    a_dom_tout: assert property (p_dom_tout) else $error("dominant past time-out");
    a_mode_norm: assert property (p_mode_norm) else $error("normal mode not taken");
    a_mode_pwr: assert property (p_mode_pwr) else $error("power-on standby not taken");
    a_inh: assert property (p_inh) else $error("inhibit low outside sleep");
    a_wake: assert property (p_wake) else $error("wake edge not signalled");
    a_wire: assert property (p_wire) else $error("wire fault not indicated");
    a_off_bias: assert property (p_off_bias) else $error("bad bias with driver off");
    a_ov1: assert property (p_ov1) else $error("first time-out missed");
    a_ov2: assert property (p_ov2) else $error("second time-out missed");
    c_dom: cover property ($rose(busDrive.dominant));
    c_single: cover property ($fell(busDrive.highDriverOn));
    c_wake: cover property ($fell(errInd_n) && modeState == ftc_pkg::MODE_SLEEP);
endmodule : ftc_phy_control_chk

bind ftc_phy_control ftc_phy_control_chk i_ftc_phy_control_chk (
    .clk(clk), .reset(reset), .txData(txData), .standby_ctrl_in(standby_ctrl_in),
    .enableCtrl(enableCtrl), .wakeLocal_n(wakeLocal_n), .battery_supply(battery_supply),
    .busSense(busSense), .rxData(rxData), .errInd_n(errInd_n),
    .regulator_inhibit_out(regulator_inhibit_out), .busDrive(busDrive), .modeState(modeState)
);

// *** tb/ftc_phy_control_bench.sv ***
// Testbench of the fault-tolerant CAN transceiver control
module ftc_phy_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk = 1'b0;
    logic                    reset = 1'b1;
    logic                    stbIn = 1'b0;
    logic                    enIn = 1'b0;
    logic                    wakeLocal_n = 1'b1;
    logic                    loopOn = 1'b1;
    logic                    start = 1'b0;
    logic                    stuck = 1'b0;
    logic [7:0]              frame = 8'h00;
    ftc_pkg::ftc_bus_sense_t sense = '0;
    ftc_pkg::ftc_bus_sense_t busIn;
    logic                    echo = 1'b0;
    logic                    batIn = 1'b0;
    logic                    txData;
    logic                    rxData;
    logic                    errInd_n;
    logic                    inhibit;
    ftc_pkg::ftc_drive_t     drive;
    ftc_pkg::ftc_mode_t      mode;
    int                      n_fail = 0;
    int                      n_checks = 0;
    int                      cycles = 0;
    always #5 clk = ~clk;
    // Bus echo register and run limit
    always @(posedge clk)
    begin
        echo   <= drive.dominant;
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_fail++;
            complete_run();
        end
    end
    // Bus echoes our own drive unless a failure is being staged
    assign busIn = loopOn ? {echo, sense[3:0]} : sense;
    ftc_ctrl_model i_ftc_ctrl_model (.clk(clk), .start(start), .frame(frame), .stuck(stuck),
        .txData(txData));
    ftc_phy_control i_ftc_phy_control (.clk(clk), .reset(reset), .txData(txData),
        .standby_ctrl_in(stbIn), .enableCtrl(enIn), .wakeLocal_n(wakeLocal_n),
        .battery_supply(batIn), .busSense(busIn), .rxData(rxData), .errInd_n(errInd_n),
        .regulator_inhibit_out(inhibit), .busDrive(drive), .modeState(mode));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic set_mode(input logic s, input logic e);
        @(posedge clk);
        stbIn <= s;
        enIn <= e;
        tick(6);
    endtask : set_mode
    task automatic t_reset_state;
        tick(11);
        chk({drive, inhibit, rxData}, {5'h18, 2'b11});
        @(posedge clk);
        reset <= 1'b0;
        tick(4);
        chk(mode, ftc_pkg::MODE_STANDBY);
    endtask : t_reset_state
    task automatic t_modes;
        set_mode(1'b1, 1'b0);
        chk({mode, errInd_n}, {ftc_pkg::MODE_PWRON_SBY, 1'b0});
        set_mode(1'b1, 1'b1);
        chk({mode, errInd_n}, {ftc_pkg::MODE_NORMAL, 1'b1});
        set_mode(1'b0, 1'b1);
        chk(mode, ftc_pkg::MODE_GOTOSLEEP);
        set_mode(1'b0, 1'b0);
        chk({mode, inhibit}, {ftc_pkg::MODE_SLEEP, 1'b0});
        @(posedge clk);
        wakeLocal_n <= 1'b0;
        tick(8);
        chk({inhibit, errInd_n, rxData}, 3'b100);
        set_mode(1'b1, 1'b1);
        chk(errInd_n, 1'b1);
        set_mode(1'b0, 1'b1);
        set_mode(1'b0, 1'b0);
        @(posedge clk);
        wakeLocal_n <= 1'b1;
        tick(8);
        chk({inhibit, errInd_n}, 2'b10);
        set_mode(1'b1, 1'b0);
        chk({errInd_n, rxData}, 2'b10);
        @(posedge clk);
        batIn <= 1'b1;
        @(posedge clk);
        batIn <= 1'b0;
        tick(6);
        chk(errInd_n, 1'b0);
        set_mode(1'b1, 1'b1);
    endtask : t_modes
    task automatic t_frame(input logic [7:0] f);
        @(posedge clk);
        frame <= f;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        tick(14);
        for (int i = 7; i >= 0; i--)
        begin
            chk({drive.dominant, rxData}, {~f[i], f[i]});
            tick(20);
        end
    endtask : t_frame
    task automatic t_txd_timeout;
        @(posedge clk);
        stuck <= 1'b1;
        tick(20);
        chk(drive.dominant, 1'b1);
        tick(ftc_pkg::TXD_TIMEOUT_CYC);
        chk(drive.dominant, 1'b0);
        @(posedge clk);
        stuck <= 1'b0;
        tick(4);
        @(posedge clk);
        stuck <= 1'b1;
        tick(10);
        chk(drive.dominant, 1'b1);
        @(posedge clk);
        stuck <= 1'b0;
        tick(6);
    endtask : t_txd_timeout
    task automatic t_wire;
        @(posedge clk);
        sense.wireFault <= 1'b1;
        tick(8);
        chk({errInd_n, drive[4:2]}, 4'b0110);
        @(posedge clk);
        sense.wireFault <= 1'b0;
        tick(8);
        chk(errInd_n, 1'b1);
    endtask : t_wire
    task automatic t_overvolt;
        @(posedge clk);
        loopOn <= 1'b0;
        sense.diffDominant <= 1'b1;
        sense.highOverVolt <= 1'b1;
        sense.highDominant <= 1'b1;
        tick(ftc_pkg::FAIL_T1_CYC / 2);
        chk(errInd_n, 1'b1);
        tick(ftc_pkg::FAIL_T1_CYC / 2 + 10);
        chk({errInd_n, drive.highDriverOn, rxData}, 3'b010);
        @(posedge clk);
        sense.highDominant <= 1'b0;
        tick(6);
        chk(rxData, 1'b1);
        tick(ftc_pkg::FAIL_T2_CYC - ftc_pkg::FAIL_T1_CYC);
        chk(drive[4:2], 3'b011);
        @(posedge clk);
        sense.lowDominant <= 1'b1;
        tick(6);
        chk(rxData, 1'b0);
        @(posedge clk);
        sense <= '0;
        loopOn <= 1'b1;
        tick(ftc_pkg::RECOVER_CYC + 10);
        chk({errInd_n, drive.highDriverOn, drive.highTermWeakPulldown}, 3'b110);
    endtask : t_overvolt
    task automatic complete_run;
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    initial
    begin
        t_reset_state();
        t_modes();
        t_frame(8'ha6);
        t_frame(8'h3c);
        t_txd_timeout();
        t_wire();
        t_overvolt();
        complete_run();
    end
endmodule : ftc_phy_control_bench
